// *** pkg/spi_engine_params.svh ***
`ifndef SPI_ENGINE_PARAMS_SVH
`define SPI_ENGINE_PARAMS_SVH
// Control header bit positions
`define HDR_DNC_BIT 31
`define HDR_BAD_BIT 30
`define HDR_WRITE_BIT 29
`define HDR_NOINC_BIT 28
`define HDR_MMS_MSB 27
`define HDR_MMS_LSB 24
`define HDR_ADDR_MSB 23
`define HDR_ADDR_LSB 8
`define HDR_COUNT_MSB 7
`define HDR_COUNT_LSB 1
// Data header / footer bit positions
`define DH_VALID_BIT 21
`define DH_START_BIT 20
`define DH_END_BIT 14
`define FT_EXST_BIT 31
`define FT_VALID_BIT 21
`define FT_START_BIT 20
`define FT_END_BIT 14
`define FT_DROP_BIT 13
`define FT_OFFSET_MSB 12
`define FT_OFFSET_LSB 7
`define FT_CREDIT_MSB 5
`define FT_CREDIT_LSB 1
// Fixed answer after a bad header
`define ERR_WORD 32'h4000_0000
`define WORD_BITS 32
`endif

// *** pkg/spi_engine_pkg.sv ***
package spi_engine_pkg;
    typedef enum logic [2:0] {
        ST_HDR = 3'b000,
        ST_WRITE = 3'b001,
        ST_READ = 3'b010,
        ST_CHUNK = 3'b011,
        ST_ERROR = 3'b100
    } phase_e;
    typedef logic [31:0] word_t;
endpackage

// *** hw/pin_sync.sv ***
`timescale 1ns/1ps
// Three-stage synchroniser; change counts once stages two and three agree
module pin_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic pin,
    output logic level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // Stage one only feeds stage two
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level <= 1'b0;
        end else if (ce) begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level <= s3_q;
            end
        end
    end
endmodule // pin_sync

// *** hw/spi_engine.sv ***
`timescale 1ns/1ps
`include "spi_engine_params.svh"
module spi_engine #(
    parameter int CHUNK_WORDS = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // SPI pins, asynchronous to clk
    input wire logic cs_n_pin,
    input wire logic sclk_pin,
    input wire logic mosi_pin,
    output logic miso,
    // Register port
    output logic reg_we,
    output logic reg_re,
    output logic [3:0] reg_map,
    output logic [15:0] reg_addr,
    output logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    // Transmit / receive side
    input wire logic cut_through,
    input wire logic protect_en,
    input wire logic [4:0] tx_credit,
    input wire logic tx_underrun_evt,
    input wire logic rx_overflow_evt,
    input wire logic rx_active,
    output logic tx_frame_drop,
    output logic tx_bad_crc,
    output logic rx_terminate,
    output logic rx_drop_host,
    // Status, cleared by writing one
    input wire logic [6:0] status_clr,
    output logic hdr_err,
    output logic tx_proto_err,
    output logic tx_overflow,
    output logic tx_underrun,
    output logic framing_loss_error,
    output logic control_protection_error,
    output logic rx_overflow
);
    ////////////////////////////////////////////////////////////////////
    logic cs_n_s;
    logic cs_sel_s;
    logic sclk_s;
    logic mosi_s;
    logic sclk_prev_q;
    logic cs_prev_q;

    // Select synced active high so reset reads as deselected, no false edge
    pin_sync u_cs (.clk(clk), .rst(rst), .ce(ce), .pin(~cs_n_pin), .level(cs_sel_s));
    assign cs_n_s = !cs_sel_s;
    pin_sync u_sck (.clk(clk), .rst(rst), .ce(ce), .pin(sclk_pin), .level(sclk_s));
    pin_sync u_mosi (.clk(clk), .rst(rst), .ce(ce), .pin(mosi_pin), .level(mosi_s));

    // Edge detectors work on the filtered levels only
    always_ff @(posedge clk) begin
        if (rst) begin
            sclk_prev_q <= 1'b0;
            cs_prev_q <= 1'b1;
        end else if (ce) begin
            sclk_prev_q <= sclk_s;
            cs_prev_q <= cs_n_s;
        end
    end

    logic rise;
    logic fall;
    logic cs_rise;
    logic cs_fall;
    assign rise = !cs_n_s && sclk_s && !sclk_prev_q;
    assign fall = !cs_n_s && !sclk_s && sclk_prev_q;
    assign cs_rise = cs_n_s && !cs_prev_q;
    assign cs_fall = !cs_n_s && cs_prev_q;

    ////////////////////////////////////////////////////////////////////
    logic [31:0] sh_in_q;
    logic [31:0] sh_out_q;
    logic [4:0] bit_q;
    logic word_done;
    logic [31:0] word_in;
    assign word_done = rise && (bit_q == 5'd31);
    assign word_in = {sh_in_q[30:0], mosi_s};

    spi_engine_pkg::phase_e phase_q;
    logic [6:0] left_q;
    logic noinc_q;
    logic in_frame_q;
    logic skip_q;
    logic footer_flag_q;
    logic [5:0] chunk_cnt_q;
    logic [31:0] next_out;
    logic parity_ok;
    logic [31:0] footer;

    // Odd parity over the whole word
    assign parity_ok = ^word_in;
    assign footer = footer_flag_q
        ? ((32'h1 << `FT_VALID_BIT) | (32'h1 << `FT_END_BIT) | (32'h1 << `FT_DROP_BIT))
        : ({27'h0, tx_credit} << `FT_CREDIT_LSB);

    // Input shifter and bit counter
    always_ff @(posedge clk) begin
        if (rst) begin
            sh_in_q <= 32'h0;
            bit_q <= 5'd0;
        end else if (ce) begin
            if (cs_fall) begin
                sh_in_q <= 32'h0;
                bit_q <= 5'd0;
            end else if (rise) begin
                sh_in_q <= word_in;
                bit_q <= bit_q + 5'd1;
            end
        end
    end

    // Output shifter: MSB first, changes on falling edge
    always_ff @(posedge clk) begin
        if (rst) begin
            sh_out_q <= 32'h0;
            miso <= 1'b0;
        end else if (ce) begin
            if (cs_fall) begin
                sh_out_q <= 32'h0;
                miso <= 1'b0;
            end else if (word_done) begin
                sh_out_q <= next_out;
            end else if (fall) begin
                miso <= sh_out_q[31];
                sh_out_q <= {sh_out_q[30:0], 1'b0};
            end
        end
    end

    // Next outgoing word chosen per phase
    always_comb begin
        next_out = 32'h0;
        if (phase_q == spi_engine_pkg::ST_ERROR
            || (phase_q == spi_engine_pkg::ST_HDR && !parity_ok)) begin
            next_out = `ERR_WORD;
        end else if (phase_q == spi_engine_pkg::ST_HDR && !word_in[`HDR_DNC_BIT]) begin
            // Address is not loaded yet, so a control header with good parity is echoed
            next_out = word_in;
        end else if (phase_q == spi_engine_pkg::ST_WRITE) begin
            next_out = word_in;
        end else if (phase_q == spi_engine_pkg::ST_READ) begin
            next_out = reg_rdata;
        end else if (phase_q == spi_engine_pkg::ST_CHUNK && chunk_cnt_q == 6'd2) begin
            // One word early, so the footer fills the last chunk slot
            next_out = footer;
        end else if (phase_q == spi_engine_pkg::ST_HDR && CHUNK_WORDS == 1) begin
            next_out = footer;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Command sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            phase_q <= spi_engine_pkg::ST_HDR;
            left_q <= 7'h0;
            noinc_q <= 1'b0;
            reg_map <= 4'h0;
            reg_addr <= 16'h0;
            chunk_cnt_q <= 6'h0;
        end else if (ce) begin
            // Step after each write strobe, so the strobe shows its own address
            if (reg_we) begin
                reg_addr <= reg_addr + 16'h1;
            end
            if (cs_n_s) begin
                phase_q <= spi_engine_pkg::ST_HDR;
            end else if (word_done) begin
                case (phase_q)
                    spi_engine_pkg::ST_HDR: begin
                        if (!parity_ok) begin
                            phase_q <= spi_engine_pkg::ST_ERROR;
                        end else if (!word_in[`HDR_DNC_BIT]) begin
                            reg_map <= word_in[`HDR_MMS_MSB:`HDR_MMS_LSB];
                            reg_addr <= word_in[`HDR_ADDR_MSB:`HDR_ADDR_LSB];
                            noinc_q <= word_in[`HDR_NOINC_BIT];
                            left_q <= word_in[`HDR_COUNT_MSB:`HDR_COUNT_LSB];
                            phase_q <= word_in[`HDR_WRITE_BIT] ? spi_engine_pkg::ST_WRITE
                                : spi_engine_pkg::ST_READ;
                        end else begin
                            chunk_cnt_q <= 6'(CHUNK_WORDS);
                            phase_q <= spi_engine_pkg::ST_CHUNK;
                        end
                    end
                    spi_engine_pkg::ST_WRITE: begin
                        // One extra word past the count is the discarded trailer
                        if (left_q == 7'h7f) begin
                            phase_q <= spi_engine_pkg::ST_HDR;
                        end else begin
                            left_q <= left_q - 7'h1;
                        end
                    end
                    spi_engine_pkg::ST_READ: begin
                        if (left_q == 7'h7f) begin
                            phase_q <= spi_engine_pkg::ST_HDR;
                        end else begin
                            left_q <= left_q - 7'h1;
                            if (!noinc_q) begin
                                reg_addr <= reg_addr + 16'h1;
                            end
                        end
                    end
                    spi_engine_pkg::ST_CHUNK: begin
                        if (chunk_cnt_q == 6'd1) begin
                            phase_q <= spi_engine_pkg::ST_HDR;
                        end
                        chunk_cnt_q <= chunk_cnt_q - 6'd1;
                    end
                    spi_engine_pkg::ST_ERROR: phase_q <= spi_engine_pkg::ST_ERROR;
                    default: phase_q <= spi_engine_pkg::ST_HDR;
                endcase
            end
        end
    end

    // Register strobes; only words before the trailer are applied
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_we <= 1'b0;
            reg_re <= 1'b0;
            reg_wdata <= 32'h0;
        end else if (ce) begin
            reg_we <= word_done && phase_q == spi_engine_pkg::ST_WRITE && left_q != 7'h7f
                && !(protect_en && !parity_ok);
            // One strobe per word read, in step with the address it reads
            reg_re <= word_done && ((phase_q == spi_engine_pkg::ST_HDR && parity_ok
                && !word_in[`HDR_DNC_BIT] && !word_in[`HDR_WRITE_BIT])
                || (phase_q == spi_engine_pkg::ST_READ && left_q != 7'h0
                && left_q != 7'h7f));
            if (word_done) begin
                reg_wdata <= word_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Transmit frame tracking from data headers
    logic dh_taken;
    logic dh_start;
    logic dh_end;
    logic dh_valid;
    logic proto_evt;
    logic ovf_evt;
    logic loss_evt;
    logic hdrerr_tx;
    assign dh_taken = word_done && phase_q == spi_engine_pkg::ST_HDR && parity_ok
        && word_in[`HDR_DNC_BIT];
    assign dh_valid = word_in[`DH_VALID_BIT];
    assign dh_start = word_in[`DH_START_BIT];
    assign dh_end = word_in[`DH_END_BIT];
    assign ovf_evt = dh_taken && dh_valid && tx_credit == 5'h0;
    assign proto_evt = dh_taken && dh_valid && !ovf_evt && !skip_q
        && ((!in_frame_q && !dh_start) || (in_frame_q && dh_start));
    assign hdrerr_tx = word_done && phase_q == spi_engine_pkg::ST_HDR && !parity_ok
        && word_in[`HDR_DNC_BIT];
    // An aborted command is already over, so its deselect on a word boundary is no framing loss
    assign loss_evt = cs_rise && (bit_q != 5'd0 || (phase_q != spi_engine_pkg::ST_HDR
        && phase_q != spi_engine_pkg::ST_ERROR));

    always_ff @(posedge clk) begin
        if (rst) begin
            in_frame_q <= 1'b0;
            skip_q <= 1'b0;
            footer_flag_q <= 1'b0;
            tx_frame_drop <= 1'b0;
            tx_bad_crc <= 1'b0;
            rx_terminate <= 1'b0;
            rx_drop_host <= 1'b0;
        end else if (ce) begin
            tx_frame_drop <= 1'b0;
            tx_bad_crc <= 1'b0;
            rx_terminate <= 1'b0;
            rx_drop_host <= 1'b0;
            if (hdrerr_tx) begin
                in_frame_q <= 1'b0;
                tx_frame_drop <= in_frame_q;
                tx_bad_crc <= in_frame_q && cut_through;
                footer_flag_q <= 1'b1;
            end else if (loss_evt) begin
                in_frame_q <= 1'b0;
                tx_frame_drop <= in_frame_q;
                rx_terminate <= rx_active;
            end else if (ovf_evt) begin
                in_frame_q <= 1'b0;
                tx_frame_drop <= 1'b1;
            end else if (tx_underrun_evt && cut_through) begin
                in_frame_q <= 1'b0;
                skip_q <= 1'b1;
                tx_bad_crc <= 1'b1;
            end else if (dh_taken && dh_valid) begin
                if (skip_q) begin
                    skip_q <= !dh_end;
                end else begin
                    tx_frame_drop <= in_frame_q && dh_start;
                    in_frame_q <= (in_frame_q || dh_start) && !dh_end;
                end
            end
            if (rx_overflow_evt) begin
                rx_terminate <= 1'b1;
                rx_drop_host <= 1'b1;
            end
            // Footer flag lasts until the first footer of the next select
            if (phase_q == spi_engine_pkg::ST_CHUNK && word_done && chunk_cnt_q == 6'd1
                && footer_flag_q && !hdrerr_tx) begin
                footer_flag_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sticky status, set beats clear
    logic [6:0] set_v;
    logic [6:0] stat_q;
    assign set_v = {rx_overflow_evt,
                    word_done && phase_q == spi_engine_pkg::ST_WRITE && protect_en
                        && !parity_ok,
                    loss_evt || (word_done && phase_q == spi_engine_pkg::ST_WRITE
                        && protect_en && !parity_ok),
                    tx_underrun_evt && cut_through,
                    ovf_evt,
                    proto_evt,
                    word_done && phase_q == spi_engine_pkg::ST_HDR && !parity_ok};

    always_ff @(posedge clk) begin
        if (rst) begin
            stat_q <= 7'h0;
        end else if (ce) begin
            stat_q <= set_v | (stat_q & ~status_clr);
        end
    end

    assign hdr_err = stat_q[0];
    assign tx_proto_err = stat_q[1];
    assign tx_overflow = stat_q[2];
    assign tx_underrun = stat_q[3];
    assign framing_loss_error = stat_q[4];
    assign control_protection_error = stat_q[5];
    assign rx_overflow = stat_q[6];
endmodule // spi_engine

// *** verif/spi_engine_monitor.sv ***
`timescale 1ns/1ps
// Port checker for the serial engine, one clock domain
module spi_engine_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic cut_through,
    input wire logic tx_underrun_evt,
    input wire logic rx_overflow_evt,
    input wire logic [6:0] status_clr,
    input wire logic reg_we,
    input wire logic reg_re,
    input wire logic hdr_err,
    input wire logic tx_underrun,
    input wire logic framing_loss_error,
    input wire logic control_protection_error,
    input wire logic rx_overflow
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////////
    // A status bit only falls when its own clear strobe is up
    property sticky_p(s, c);
        s && !c |=> s;
    endproperty

    hdr_sticky_a: assert property (sticky_p(hdr_err, status_clr[0]))
        else $error("header error bit fell without clear");
    underrun_sticky_a: assert property (sticky_p(tx_underrun, status_clr[3]))
        else $error("underrun bit fell without clear");
    framing_sticky_a: assert property (sticky_p(framing_loss_error, status_clr[4]))
        else $error("framing loss bit fell without clear");
    underrun_flag_a: assert property (ce && cut_through && tx_underrun_evt |-> ##[1:3] tx_underrun)
        else $error("underrun event not flagged");
    overflow_flag_a: assert property (ce && rx_overflow_evt |-> ##[1:3] rx_overflow)
        else $error("receive overflow not flagged");
    protect_pair_a: assert property ($rose(control_protection_error) |-> ##[0:2] framing_loss_error)
        else $error("protection error without framing loss");
    hdr_abort_a: assert property ($rose(hdr_err) |-> !reg_we [*8])
        else $error("write strobe after bad header");
    we_pulse_a: assert property (reg_we |=> !reg_we)
        else $error("write strobe longer than one cycle");
    we_re_excl_a: assert property (reg_we |-> !reg_re)
        else $error("read and write strobes together");

    // Main scenarios reached
    cover property (reg_we);
    cover property (reg_re);
    cover property ($rose(hdr_err));
    cover property ($rose(framing_loss_error));
endmodule // spi_engine_monitor

bind spi_engine spi_engine_monitor mon (
    .clk(clk), .rst(rst), .ce(ce), .cut_through(cut_through),
    .tx_underrun_evt(tx_underrun_evt), .rx_overflow_evt(rx_overflow_evt),
    .status_clr(status_clr), .reg_we(reg_we), .reg_re(reg_re), .hdr_err(hdr_err),
    .tx_underrun(tx_underrun), .framing_loss_error(framing_loss_error),
    .control_protection_error(control_protection_error), .rx_overflow(rx_overflow)
);

// *** verif/spi_host_model.sv ***
`timescale 1ns/1ps
// Host side of the link; serial clock idles low and runs only inside frames
module spi_host_model (
    input wire logic clk,
    output logic cs_n_pin,
    output logic sclk_pin,
    output logic mosi_pin,
    input wire logic miso
);
    logic [31:0] rx_q [$];

    // Deselected, clock parked
    initial begin
        cs_n_pin = 1'b1;
        sclk_pin = 1'b0;
        mosi_pin = 1'b0;
    end

    // One transaction, words back to back; last word may be cut short
    task automatic frame(input logic [31:0] tx [$], input int last_bits);
        logic [31:0] w;
        rx_q.delete();
        @(posedge clk);
        cs_n_pin <= 1'b0;
        repeat (8) @(posedge clk);
        foreach (tx[k]) begin
            w = '0;
            for (int i = 31; i >= ((k == tx.size() - 1) ? 32 - last_bits : 0); i--) begin
                mosi_pin <= tx[k][i];
                repeat (4) @(posedge clk);
                sclk_pin <= 1'b1;
                repeat (4) @(posedge clk);
                w[i] = miso; // Sampled late in the high phase, well after the update
                sclk_pin <= 1'b0;
            end
            rx_q.push_back(w);
        end
        repeat (8) @(posedge clk);
        cs_n_pin <= 1'b1;
        mosi_pin <= ~mosi_pin; // Released line shows no stale bit
        repeat (16) @(posedge clk);
    endtask
endmodule // spi_host_model

// *** verif/tb.sv ***
`timescale 1ns/1ps
`include "spi_engine_params.svh"
module tb;
    localparam int CW = 4;
    logic clk, rst, ce, cut_through, protect_en, tx_underrun_evt, rx_overflow_evt, rx_active;
    logic miso, reg_we, reg_re, tx_frame_drop, tx_bad_crc, rx_terminate, rx_drop_host;
    logic hdr_err, tx_proto_err, tx_overflow, tx_underrun, framing_loss_error, rx_overflow;
    logic control_protection_error, cs_n_pin, sclk_pin, mosi_pin, term_seen;
    logic [4:0] tx_credit;
    logic [6:0] status_clr, st;
    logic [3:0] reg_map;
    logic [15:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [52:0] acc_q [$];
    logic [31:0] q [$];
    int fails = 0;
    int checks_done = 0;

    // Status in clear-strobe order
    assign st = {rx_overflow, control_protection_error, framing_loss_error, tx_underrun,
                 tx_overflow, tx_proto_err, hdr_err};
    // Register stand-in: contents tell addresses apart
    assign reg_rdata = {~reg_addr, reg_addr};

    spi_engine #(.CHUNK_WORDS(CW)) uut (
        .clk(clk), .rst(rst), .ce(ce), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
        .mosi_pin(mosi_pin), .miso(miso), .reg_we(reg_we), .reg_re(reg_re),
        .reg_map(reg_map), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .cut_through(cut_through), .protect_en(protect_en), .tx_credit(tx_credit),
        .tx_underrun_evt(tx_underrun_evt), .rx_overflow_evt(rx_overflow_evt),
        .rx_active(rx_active), .tx_frame_drop(tx_frame_drop), .tx_bad_crc(tx_bad_crc),
        .rx_terminate(rx_terminate), .rx_drop_host(rx_drop_host), .status_clr(status_clr),
        .hdr_err(hdr_err), .tx_proto_err(tx_proto_err), .tx_overflow(tx_overflow),
        .tx_underrun(tx_underrun), .framing_loss_error(framing_loss_error),
        .control_protection_error(control_protection_error), .rx_overflow(rx_overflow)
    );
    spi_host_model host (.clk(clk), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
        .mosi_pin(mosi_pin), .miso(miso));

    ////////////////////////////////////////////////////////////////////////////////
    // Core clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Log of register strobes and receive terminations
    always @(posedge clk) begin
        if (reg_we || reg_re) acc_q.push_back({reg_we, reg_map, reg_addr, reg_wdata});
        if (rx_terminate) term_seen <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] par(input logic [31:0] h);
        return {h[31:1], ~^h[31:1]};
    endfunction
    function automatic logic [31:0] hdr(input logic wr, noinc, input logic [15:0] a,
                                        input logic [6:0] cnt);
        return par({2'b00, wr, noinc, 4'h1, a, cnt, 1'b0});
    endfunction
    function automatic logic [31:0] rd(input logic [15:0] a);
        return {~a, a};
    endfunction
    task automatic chk(input logic [52:0] got, input logic [52:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic run(input int bits);
        acc_q.delete();
        host.frame(q, bits);
    endtask
    task automatic clr(input logic [6:0] m);
        @(posedge clk);
        status_clr <= m;
        @(posedge clk);
        status_clr <= 7'h00;
        repeat (2) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Write of three words, trailer, then a read with no gap
    task automatic t_write_read();
        q = {hdr(1'b1, 1'b0, 16'h0030, 7'h02), 32'h1111_0001, 32'h2222_0002, 32'h3333_0003,
             32'hdead_beef, hdr(1'b0, 1'b0, 16'h0040, 7'h00), 32'hffff_ffff, 32'h0};
        run(32);
        chk(53'(host.rx_q[1]), 53'(q[0]));
        for (int k = 0; k < 3; k++) begin
            chk(53'(host.rx_q[k + 2]), 53'(q[k + 1]));
            chk(acc_q[k], {1'b1, 4'h1, 16'h0030 + 16'(k), q[k + 1]});
        end
        chk(53'(acc_q.size()), 53'd4);
        chk(53'(acc_q[3][52:32]), {1'b0, 4'h1, 16'h0040});
        chk(53'(host.rx_q[7]), 53'(rd(16'h0040)));
        $display("write then read done");
    endtask
    // Three-word read, host sends a valid write header as filler
    task automatic t_read(input logic noinc);
        logic [15:0] a;
        q = {hdr(1'b0, noinc, 16'h0050, 7'h02), hdr(1'b1, 1'b0, 16'h0060, 7'h00), 32'h0, 32'h1,
             32'h0};
        run(32);
        chk(53'(acc_q.size()), 53'd3);
        for (int k = 0; k < 3; k++) begin
            a = 16'h0050 + (noinc ? 16'h0 : 16'(k));
            chk(53'(acc_q[k][52:32]), {1'b0, 4'h1, a});
            chk(53'(host.rx_q[k + 2]), 53'(rd(a)));
        end
        $display("read done");
    endtask
    // Broken header parity, control or data
    task automatic t_parity(input logic dat);
        logic [31:0] h, f;
        h = dat ? par(32'h8030_0000) : hdr(1'b1, 1'b0, 16'h0070, 7'h01);
        q = {h ^ 32'h1, 32'h0, 32'h1, 32'h2, 32'h3};
        run(32);
        for (int k = 1; k < 5; k++) chk(53'(host.rx_q[k]), 53'(`ERR_WORD));
        chk(53'(acc_q.size()), 53'd0);
        chk(53'(hdr_err), 53'd1);
        if (dat) begin
            q = {par(32'h8000_0000), 32'h0, 32'h0, 32'h0, 32'h0};
            run(32);
            f = host.rx_q[CW];
            chk(53'({f[`FT_VALID_BIT], f[`FT_END_BIT], f[`FT_DROP_BIT],
                     f[`FT_OFFSET_MSB:`FT_OFFSET_LSB]}),
                53'h1c0);
        end
        clr(7'h01);
        chk(53'(hdr_err), 53'd0);
        if (!dat) begin
            q = {h, 32'hc0c0_0001, 32'hc0c0_0002, 32'h0};
            run(32);
            chk(acc_q[0], {1'b1, 4'h1, 16'h0070, 32'hc0c0_0001});
        end
        $display("parity done");
    endtask
    // Deselect in mid word with a receive frame under way
    task automatic t_framing();
        rx_active <= 1'b1;
        term_seen <= 1'b0;
        q = {hdr(1'b1, 1'b0, 16'h0080, 7'h01), 32'h5};
        run(16);
        chk(53'(framing_loss_error), 53'd1);
        chk(53'(acc_q.size()), 53'd0);
        chk(53'(term_seen), 53'd1);
        rx_active <= 1'b0;
        clr(7'h7f);
        $display("framing done");
    endtask
    // Protected write with bad data parity, then a clean retry
    task automatic t_protect();
        protect_en <= 1'b1;
        q = {hdr(1'b1, 1'b0, 16'h0090, 7'h00), 32'h0, 32'h0};
        run(32);
        chk(53'(acc_q.size()), 53'd0);
        chk(53'(st), 53'h30);
        clr(7'h7f);
        q = {hdr(1'b1, 1'b0, 16'h0090, 7'h00), 32'h1, 32'h1};
        run(32);
        chk(acc_q[0], {1'b1, 4'h1, 16'h0090, 32'h1});
        protect_en <= 1'b0;
        $display("protect done");
    endtask
    // n chunks of header h with given credit, then the expected status
    task automatic chunk(input logic [4:0] cr, input logic [31:0] h, input int n,
                         input logic [6:0] m);
        tx_credit <= cr;
        q = {};
        for (int i = 0; i < n * (CW + 1); i++) q.push_back((i % (CW + 1)) ? 32'h0 : h);
        run(32);
        chk(53'(st), 53'(m));
        clr(7'h7f);
    endtask
    task automatic t_events();
        cut_through <= 1'b1;
        tx_underrun_evt <= 1'b1;
        rx_overflow_evt <= 1'b1;
        @(posedge clk);
        tx_underrun_evt <= 1'b0;
        rx_overflow_evt <= 1'b0;
        repeat (4) @(posedge clk);
        chk(53'(st), 53'h48);
        clr(7'h7f);
        cut_through <= 1'b0;
        // Underrun left data ignored until a frame end arrives
        chunk(5'h1f, par(32'h8020_4000), 1, 7'h00);
        chunk(5'h00, par(32'h8030_0000), 1, 7'h04);
        chunk(5'h1f, par(32'h8020_0000), 1, 7'h02);
        chunk(5'h1f, par(32'h8030_0000), 2, 7'h02);
        $display("events done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        cut_through = 1'b0;
        protect_en = 1'b0;
        tx_underrun_evt = 1'b0;
        rx_overflow_evt = 1'b0;
        rx_active = 1'b0;
        tx_credit = 5'h1f;
        status_clr = 7'h00;
        term_seen = 1'b0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_write_read();
        t_read(1'b0);
        t_read(1'b1);
        t_parity(1'b0);
        t_parity(1'b1);
        t_framing();
        t_protect();
        t_events();
        complete_run();
    end
    // Hang guard, about three times the expected run
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        complete_run();
    end
endmodule // tb
